/* File: hdl/astc_defs.vh */
// Constants for the avionics serial transmit control block.
// Assumes inclusion by bare name from hdl/ design files only.
`ifndef ASTC_DEFS_VH
`define ASTC_DEFS_VH

// Bits per serial word.
`define ASTC_WORD_BITS 16
// Words after which the controller role reports message done.
`define ASTC_BC_WORDS 6'h21
// Word count meaning for an all-zero count field.
`define ASTC_ZERO_COUNT 6'h20
// Position of the transmit/receive bit in a command word (MSB first).
`define ASTC_TR_BIT 10
// Position of the top bit of the address field.
`define ASTC_ADDR_MSB 15
// Position of the low end of the address field.
`define ASTC_ADDR_LSB 11
// Position of the top bit of the word count field.
`define ASTC_COUNT_MSB 4
// Position of the low end of the word count field.
`define ASTC_COUNT_LSB 0
// Reset value of the holding buffer.
`define ASTC_BUF_RST 16'h0000

`endif

/* File: hdl/astc_top.v */
// Transmit-side control of a serial word converter: encoder handshake,
// holding buffer to shift register transfer, message done and transmit enable.
// Assumes all pin inputs are asynchronous to CLK_SYS and are much slower
// than it (shift clock and envelopes at about 12.5 MHz or less).
//
// How it works
// - Ready window means encoder accepts serial data.
// - Window low copies holding buffer into shifter.
// - Data request high when holding register free.
// - Terminal receive: message done low after counted words.
// - Transmit: message done marks words all sent.
// - Controller role: done after 33 sent words.
// - Transmit enable output starts encoder sending.
// - Controller role: each request pulse toggles enable.
// - Controller role: second pulse clears enable.
// - Terminal: transmit command interrupt, pulse sets enable.
// - Terminal: last word window or pulse clears.
// - Terminal: last data sync fall sets enable.
// - Enable from receive cleared in next window.
// - Role select 0 controller, 1 terminal.
// - NRZ serial out, one bit per shift clock.
// - Transmit interrupt on own address, bit six.
// - Last five command bits give word count.
// - Most significant bit goes first.
`include "astc_defs.vh"

module astc_top
#(
  parameter WORD_BITS = `ASTC_WORD_BITS
)
(
  input  wire       CLK_SYS,
  input  wire       ARST_N,
  input  wire       ENCODER_READY_WINDOW,
  input  wire       SERIAL_SHIFT_CLOCK,
  input  wire       CONTROLLER_ROLE_SELECT,
  input  wire       TRANSMIT_REQUEST_PULSE,
  input  wire       DATA_SYNC_ENVELOPE,
  input  wire       COMMAND_SYNC_ENVELOPE,
  input  wire       RECEIVE_CLOCK,
  input  wire       RECEIVE_DATA,
  input  wire [4:0] TERMINAL_ADDRESS_INPUTS,
  input  wire       INTERRUPT_ACKNOWLEDGE_N,
  input  wire       TAKE_DATA_STROBE,
  input  wire [7:0] HOST_DATA,
  output reg        HOLDING_BUFFER_REQUEST,
  output reg        MESSAGE_DONE_N,
  output reg        TRANSMIT_ENABLE,
  output reg        SERIAL_OUT_DATA,
  output reg        TRANSMIT_INTERRUPT_N
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------

  // Two-stage synchronisers for nine single-bit pins, seven of them edge-detected; stage one feeds stage two only.
  reg [8:0] sync_a;              // First stage.
  reg [8:0] sync_b;              // Second stage, the only one logic reads.
  reg [8:0] sync_c;              // Previous value of the second stage, for edges.
  reg [4:0] addr_a;              // Address first stage.
  reg [4:0] addr_b;              // Address second stage.
  reg [7:0] data_a;              // Host byte first stage.
  reg [7:0] data_b;              // Host byte second stage.
  reg       ack_a;               // Acknowledge first stage.
  reg       ack_b;               // Acknowledge second stage, the only one logic reads.

  // Sample all pins on every system clock.
  always @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
      sync_c <= 9'h000;
      addr_a <= 5'h00;
      addr_b <= 5'h00;
      data_a <= 8'h00;
      data_b <= 8'h00;
      // Acknowledge idles high; resetting it low would fake a clear.
      ack_a  <= 1'b1;
      ack_b  <= 1'b1;
    end
    else
    begin
      sync_a <= {TAKE_DATA_STROBE, RECEIVE_DATA, RECEIVE_CLOCK, COMMAND_SYNC_ENVELOPE,
                 DATA_SYNC_ENVELOPE, TRANSMIT_REQUEST_PULSE, CONTROLLER_ROLE_SELECT,
                 SERIAL_SHIFT_CLOCK, ENCODER_READY_WINDOW};
      sync_b <= sync_a;
      sync_c <= sync_b;
      addr_a <= TERMINAL_ADDRESS_INPUTS;
      addr_b <= addr_a;
      data_a <= HOST_DATA;
      data_b <= data_a;
      ack_a  <= INTERRUPT_ACKNOWLEDGE_N;
      ack_b  <= ack_a;
    end
  end

  // Synchronised levels and edges.
  wire window    = sync_b[0];                    // Encoder ready window level.
  wire win_fall  = sync_c[0] & ~sync_b[0];       // Window closed.
  wire serial_shift_clock_up  = sync_b[1] & ~sync_c[1];       // Rising transmit shift clock.
  wire terminal  = sync_b[2];                    // Role: 1 terminal, 0 controller.
  wire req_rise  = sync_b[3] & ~sync_c[3];       // One request pulse, seen once.
  wire dsync     = sync_b[4];                    // Data sync envelope level.
  wire dsync_up  = sync_b[4] & ~sync_c[4];       // Data word starts.
  wire dsync_dn  = ~sync_b[4] & sync_c[4];       // Data word ends.
  wire csync     = sync_b[5];                    // Command sync envelope level.
  wire csync_up  = sync_b[5] & ~sync_c[5];       // Command word starts.
  wire csync_dn  = ~sync_b[5] & sync_c[5];       // Command word ends.
  wire rxclk_up  = sync_b[6] & ~sync_c[6];       // Rising receive clock.
  wire rx_bit    = sync_b[7];                    // Received serial bit.
  wire tde_rise  = sync_b[8] & ~sync_c[8];       // Host byte strobe.

  // ------------------------------------------------------------
  // Word count helper
  // ------------------------------------------------------------

  // Turns the five-bit count field into a word count; zero means thirty-two.
  function [5:0] word_count;
    input [4:0] field;
    begin
      word_count = (field == 5'h00) ? `ASTC_ZERO_COUNT : {1'b0, field};
    end
  endfunction

  // ------------------------------------------------------------
  // Receive command decode
  // ------------------------------------------------------------

  reg [15:0] rx_shift;           // Receive shift register, MSB first.
  reg [5:0]  rx_target;          // Words expected in this message.
  reg [5:0]  rx_count;           // Data words received so far.
  reg        rx_active;          // A receive message addressed to us is open.

  // Shift the receive stream MSB first and decode each command.
  always @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rx_shift  <= 16'h0000;
      rx_target <= 6'h00;
      rx_count  <= 6'h00;
      rx_active <= 1'b0;
      TRANSMIT_INTERRUPT_N <= 1'b1;
    end
    else
    begin
      if (rxclk_up && (dsync || csync))
        rx_shift <= {rx_shift[14:0], rx_bit};
      if (csync_dn && rx_shift[`ASTC_ADDR_MSB:`ASTC_ADDR_LSB] == addr_b)
      begin
        rx_target <= word_count(rx_shift[`ASTC_COUNT_MSB:`ASTC_COUNT_LSB]);
        rx_count  <= 6'h00;
        rx_active <= ~rx_shift[`ASTC_TR_BIT];
      end
      else if (dsync_dn && rx_active)
        rx_count <= rx_count + 6'h01;
      // Set wins over acknowledge.
      if (csync_dn && rx_shift[`ASTC_ADDR_MSB:`ASTC_ADDR_LSB] == addr_b && rx_shift[`ASTC_TR_BIT])
        TRANSMIT_INTERRUPT_N <= 1'b0;
      else if (!ack_b)
        TRANSMIT_INTERRUPT_N <= 1'b1;
    end
  end

  // Last data word of a receive message has just ended.
  wire rx_last = dsync_dn && rx_active && (rx_count + 6'h01 == rx_target);

  // ------------------------------------------------------------
  // Holding buffer and transmit shifter
  // ------------------------------------------------------------

  reg [15:0] hold;               // Transmit holding buffer.
  reg        hold_full;          // Holding buffer has a whole word.
  reg        byte_half;          // Next strobe fills the low byte.
  reg [15:0] tx_shift;           // Transmit shift register.
  reg [5:0]  tx_count;           // Words sent in this message.
  reg [5:0]  tx_target;          // Words to send in this message.
  reg        from_rx;            // Enable was raised by a received message.

  // Host bytes fill the buffer high byte first; window low moves it on.
  always @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      hold      <= `ASTC_BUF_RST;
      hold_full <= 1'b0;
      byte_half <= 1'b0;
      tx_shift  <= `ASTC_BUF_RST;
      tx_count  <= 6'h00;
      tx_target <= 6'h00;
      from_rx   <= 1'b0;
      HOLDING_BUFFER_REQUEST <= 1'b0;
      MESSAGE_DONE_N         <= 1'b1;
      TRANSMIT_ENABLE        <= 1'b0;
      SERIAL_OUT_DATA        <= 1'b0;
    end
    else
    begin
      // Two strobes make one word.
      if (tde_rise && !hold_full)
      begin
        if (!byte_half)
          hold[15:8] <= data_b;
        else
          hold[7:0] <= data_b;
        byte_half <= ~byte_half;
        hold_full <= byte_half;
      end
      else if (!window && hold_full)
      begin
        tx_shift  <= hold;
        hold_full <= 1'b0;
      end
      // Shift one NRZ bit per shift clock inside the window.
      if (window && serial_shift_clock_up)
      begin
        SERIAL_OUT_DATA <= tx_shift[WORD_BITS-1];
        tx_shift <= {tx_shift[14:0], 1'b0};
      end
      HOLDING_BUFFER_REQUEST <= ~hold_full;

      // Enable control per role.
      if (!terminal)
      begin
        from_rx <= 1'b0;
        if (req_rise)
        begin
          TRANSMIT_ENABLE <= ~TRANSMIT_ENABLE;
          tx_count  <= 6'h00;
          tx_target <= `ASTC_BC_WORDS;
          MESSAGE_DONE_N <= 1'b1;
        end
      end
      else if (req_rise && TRANSMIT_ENABLE)
      begin
        // A pulse ends either kind of transmit, so forget where it came from.
        TRANSMIT_ENABLE <= 1'b0;
        from_rx <= 1'b0;
      end
      else if (req_rise && !TRANSMIT_INTERRUPT_N)
      begin
        TRANSMIT_ENABLE <= 1'b1;
        from_rx <= 1'b0;
        tx_count  <= 6'h00;
        tx_target <= rx_target + 6'h01;
        MESSAGE_DONE_N <= 1'b1;
      end
      else if (rx_last)
      begin
        TRANSMIT_ENABLE <= 1'b1;
        from_rx <= 1'b1;
        MESSAGE_DONE_N <= 1'b0;
      end
      else if (win_fall && TRANSMIT_ENABLE && from_rx)
      begin
        TRANSMIT_ENABLE <= 1'b0;
        from_rx <= 1'b0;
      end
      else if (win_fall && TRANSMIT_ENABLE && tx_count + 6'h01 == tx_target)
        TRANSMIT_ENABLE <= 1'b0;

      // Count words sent; done low when the target is met.
      if (win_fall && TRANSMIT_ENABLE && !from_rx)
      begin
        tx_count <= tx_count + 6'h01;
        if (tx_count + 6'h01 == tx_target)
          MESSAGE_DONE_N <= 1'b0;
      end
      // A new command while idle opens a new message, so done goes back high.
      if (csync_up && !TRANSMIT_ENABLE)
        MESSAGE_DONE_N <= 1'b1;
    end
  end

endmodule

/* File: test/astc_top_sva.sv */
// Checker for the transmit control block: enable, message done and request.
// Assumes it sees only the top module ports; bound after the module.
module astc_top_chk (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic ENCODER_READY_WINDOW,
  input wire logic CONTROLLER_ROLE_SELECT,
  input wire logic TRANSMIT_REQUEST_PULSE,
  input wire logic COMMAND_SYNC_ENVELOPE,
  input wire logic INTERRUPT_ACKNOWLEDGE_N,
  input wire logic TAKE_DATA_STROBE,
  input wire logic HOLDING_BUFFER_REQUEST,
  input wire logic MESSAGE_DONE_N,
  input wire logic TRANSMIT_ENABLE,
  input wire logic TRANSMIT_INTERRUPT_N
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Window falls sent with enable high in controller role, counted from the enable rise.
  // ----
  logic [5:0] n_fall;
  logic       te_q;
  logic       win_q;
  always @(posedge CLK_SYS or negedge ARST_N)
  begin
    te_q  <= ARST_N & TRANSMIT_ENABLE;
    win_q <= ARST_N & ENCODER_READY_WINDOW;
    if (!ARST_N || (TRANSMIT_ENABLE && !te_q))
      n_fall <= 6'h00;
    else if (win_q && !ENCODER_READY_WINDOW && TRANSMIT_ENABLE && !CONTROLLER_ROLE_SELECT && n_fall != 6'h3f)
      n_fall <= n_fall + 6'h01;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  a_enable_toggle: assert property ($rose(TRANSMIT_REQUEST_PULSE) && !CONTROLLER_ROLE_SELECT |-> ##[3:6] $changed(TRANSMIT_ENABLE))
    else $error("enable did not toggle on request");
  a_enable_cause: assert property ($changed(TRANSMIT_ENABLE) && !CONTROLLER_ROLE_SELECT |-> $past(TRANSMIT_REQUEST_PULSE, 3) || $past(TRANSMIT_REQUEST_PULSE, 4) || $past(TRANSMIT_REQUEST_PULSE, 5) || $past(TRANSMIT_REQUEST_PULSE, 6))
    else $error("enable changed without request");
  a_done_count: assert property ($fell(MESSAGE_DONE_N) && !CONTROLLER_ROLE_SELECT |-> n_fall == 6'h21)
    else $error("done fell at wrong word count");
  a_done_timely: assert property ($rose(n_fall == 6'h21) && !CONTROLLER_ROLE_SELECT |-> ##[1:6] !MESSAGE_DONE_N)
    else $error("done late after last word");
  a_term_set: assert property ($rose(TRANSMIT_REQUEST_PULSE) && CONTROLLER_ROLE_SELECT && !TRANSMIT_INTERRUPT_N && !TRANSMIT_ENABLE |-> ##[3:6] TRANSMIT_ENABLE)
    else $error("terminal request did not set enable");
  a_ack_clears: assert property ($fell(INTERRUPT_ACKNOWLEDGE_N) && !COMMAND_SYNC_ENVELOPE |-> ##[2:6] TRANSMIT_INTERRUPT_N)
    else $error("acknowledge did not clear interrupt");
  a_req_fall: assert property ($fell(HOLDING_BUFFER_REQUEST) |-> $past(TAKE_DATA_STROBE, 3) || $past(TAKE_DATA_STROBE, 4) || $past(TAKE_DATA_STROBE, 5) || $past(TAKE_DATA_STROBE, 6))
    else $error("request fell without strobe");
  a_req_rise: assert property ($rose(HOLDING_BUFFER_REQUEST) |-> !$past(ENCODER_READY_WINDOW, 3) || !$past(ENCODER_READY_WINDOW, 4) || !$past(ENCODER_READY_WINDOW, 5))
    else $error("buffer freed while window high");
endmodule
bind astc_top astc_top_chk u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .ENCODER_READY_WINDOW(ENCODER_READY_WINDOW),
  .CONTROLLER_ROLE_SELECT(CONTROLLER_ROLE_SELECT), .TRANSMIT_REQUEST_PULSE(TRANSMIT_REQUEST_PULSE),
  .COMMAND_SYNC_ENVELOPE(COMMAND_SYNC_ENVELOPE), .INTERRUPT_ACKNOWLEDGE_N(INTERRUPT_ACKNOWLEDGE_N),
  .TAKE_DATA_STROBE(TAKE_DATA_STROBE), .HOLDING_BUFFER_REQUEST(HOLDING_BUFFER_REQUEST),
  .MESSAGE_DONE_N(MESSAGE_DONE_N), .TRANSMIT_ENABLE(TRANSMIT_ENABLE), .TRANSMIT_INTERRUPT_N(TRANSMIT_INTERRUPT_N));

/* File: test/astc_enc_model.sv */
// Encoder model: opens a window, clocks 16 bits out and collects them.
// Assumes the bench raises sends once per word that it has loaded.
module astc_enc_model (
  input  wire logic  clk,
  input  wire logic  transmit_enable,
  input  wire logic  serial_out_data,
  input  int         sends,
  output logic       ready_window,
  output logic       shift_clock,
  output logic [15:0] word,
  output int         words
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ready_window, shift_clock, word, words} = '0;
  // Odd words start promptly, even ones slowly; the clock stands low between frames.
  always @(negedge clk)
    if (words < sends && transmit_enable)
    begin
      repeat (words % 2 ? 3 : 25) @(negedge clk);
      ready_window = 1'b1;
      repeat (16)
      begin
        repeat (5) @(negedge clk);
        shift_clock = 1'b1;
        repeat (5) @(negedge clk);
        shift_clock = 1'b0;
        word = {word[14:0], serial_out_data};
      end
      repeat (5) @(negedge clk);
      ready_window = 1'b0;
      words++;
    end
endmodule

/* File: test/test_astc_top.sv */
// Bench for the transmit control block in both roles.
// Assumes the encoder model answers each loaded word.
module test_astc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 0, ARST_N = 0, ROLE = 0, REQ = 0, DSE = 0, CSE = 0, RCK = 0, RDAT = 0, ACK_N = 1, TDS = 0;
  logic [7:0] HD = 8'h00;
  wire HBR, DONE_N, TE, SOD, INT_N, WIN, SCK;
  wire [15:0] wd;
  int words, sends = 0, error_cnt = 0, n_tests = 0;
  always #4 CLK_SYS = ~CLK_SYS;
  astc_top DUT (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .ENCODER_READY_WINDOW(WIN), .SERIAL_SHIFT_CLOCK(SCK),
    .CONTROLLER_ROLE_SELECT(ROLE), .TRANSMIT_REQUEST_PULSE(REQ), .DATA_SYNC_ENVELOPE(DSE),
    .COMMAND_SYNC_ENVELOPE(CSE), .RECEIVE_CLOCK(RCK), .RECEIVE_DATA(RDAT), .TERMINAL_ADDRESS_INPUTS(5'h13),
    .INTERRUPT_ACKNOWLEDGE_N(ACK_N), .TAKE_DATA_STROBE(TDS), .HOST_DATA(HD), .HOLDING_BUFFER_REQUEST(HBR),
    .MESSAGE_DONE_N(DONE_N), .TRANSMIT_ENABLE(TE), .SERIAL_OUT_DATA(SOD), .TRANSMIT_INTERRUPT_N(INT_N));
  astc_enc_model u_enc (.clk(CLK_SYS), .transmit_enable(TE), .serial_out_data(SOD), .sends(sends),
    .ready_window(WIN), .shift_clock(SCK), .word(wd), .words(words));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  task automatic pulse_req;
    REQ = 1;
    cyc(4);
    REQ = 0;
    cyc(4);
  endtask
  // Loads one word as two bytes, high byte first, then lets the encoder take it.
  task automatic put_send(input logic [15:0] w);
    for (int b = 1; b >= 0; b--)
    begin
      HD = w[8*b +: 8];
      cyc(1);
      TDS = 1;
      cyc(3);
      TDS = 0;
      cyc(3);
    end
    sends++;
    for (int k = 0; k < 4000 && words < sends; k++) cyc(1);
    cyc(6);
    chk(wd, w);
  endtask
  // Sends one received word, most significant bit first, in a command or data envelope.
  task automatic rx(input logic [15:0] w, input logic is_data);
    {DSE, CSE} = is_data ? 2'b10 : 2'b01;
    for (int i = 15; i >= 0; i--)
    begin
      RDAT = w[i];
      cyc(3);
      RCK = 1;
      cyc(5);
      RCK = 0;
      cyc(2);
    end
    {DSE, CSE} = 2'b00;
    RDAT = ~RDAT;
    cyc(6);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    cyc(10);
    ARST_N = 1;
    cyc(3);
    chk({HBR, DONE_N, TE, INT_N}, 16'h000d);
    pulse_req();
    chk(TE, 1);
    for (int i = 0; i < 33; i++)
    begin
      put_send(16'hc3a5 ^ 16'(i * 1057));
      chk({HBR, DONE_N}, {1'b1, i < 32});
    end
    pulse_req();
    chk(TE, 0);
    ROLE = 1;
    pulse_req();
    chk(TE, 0);
    rx(16'h9c21, 1'b0);
    chk(INT_N, 0);
    ACK_N = 0;
    cyc(6);
    ACK_N = 1;
    chk(INT_N, 1);
    rx(16'h9c21, 1'b0);
    pulse_req();
    chk(TE, 1);
    put_send(16'h9800);
    put_send(16'h5a3c);
    chk({TE, DONE_N}, 0);
    // Receive command for two data words; the last one raises enable for the status reply.
    rx(16'h9822, 1'b0);
    chk(DONE_N, 1);
    rx(16'h1234, 1'b1);
    chk(TE, 0);
    rx(16'h5678, 1'b1);
    chk(TE, 1);
    chk(DONE_N, 0);
    put_send(16'h9800);
    chk(TE, 0);
    close_out();
  end
endmodule
